// File: hdl/ierp_pkg.sv
// Shared constants and types for the serial EEPROM read path
package ierp_pkg;

  localparam logic [3:0] IERP_DEV_PATTERN   = 4'hA;  // Fixed top nibble of slave address
  localparam logic [3:0] IERP_BITS_PER_BYTE = 4'h8;  // Bits received before the ninth clock
  localparam logic [3:0] IERP_LAST_TX_BIT   = 4'h7;  // Shifts done when the falling edge that ends a sent byte arrives
  localparam logic [7:0] IERP_ERASED        = 8'hFF; // Array contents after reset
  localparam int         IERP_KBITS_DEF     = 2;     // Default array size in kilobits
  localparam int         IERP_FIFO_DEPTH    = 8;     // Load FIFO depth in words
  localparam int         IERP_BYTE_ADDR_W   = 8;     // Width of the byte address on the bus
  localparam logic       IERP_SYNC_RST      = 1'b0;  // Synchroniser value after reset

  typedef enum logic [2:0] {
    ST_RESET,
    ST_IDLE,
    ST_DEVADDR,
    ST_ADDR_ACK,
    ST_BYTEADDR,
    ST_BA_ACK,
    ST_TX,
    ST_TX_ACK
  } ierp_state_t;

endpackage

// File: hdl/ierp_top.sv
// Read path of a serial EEPROM slave, with its array load FIFO
`timescale 1ns/1ps

module ierp_fifo
  import ierp_pkg::*;
#(
  parameter int W     = 8,
  parameter int DEPTH = IERP_FIFO_DEPTH
)(
  input  wire logic         clk,       // Block clock
  input  wire logic         rst,       // Synchronous reset, high
  input  wire logic         in_valid,  // Source offers a word
  output logic              in_ready,  // FIFO can take a word
  input  wire logic [W-1:0] in_data,   // Word offered
  output logic              out_valid, // FIFO holds a word
  input  wire logic         out_ready, // Sink takes the word
  output logic [W-1:0]      out_data   // Oldest word
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  wire           push;
  wire           pop;

  // DEPTH must be a power of two so the pointers wrap by themselves
  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk)
  begin
    if (push)
      mem_q[wr_q] <= in_data;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
      if (push && !pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop && !push)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule

module ierp_top
  import ierp_pkg::*;
#(
  parameter int KBITS  = IERP_KBITS_DEF,                   // 2, 4, 8 or 16
  parameter int ADDR_W = 8 + $clog2(KBITS / 2)             // Follows from KBITS
)(
  input  wire logic              ref_clk,           // Block clock, 250 MHz
  input  wire logic              sys_rst,           // Synchronous reset, high
  input  wire logic              por_ok,            // Supply above trigger level
  input  wire logic              scl_i,             // Bus clock pin level
  input  wire logic              sda_i,             // Bus data pin level
  output logic                   sda_o,             // Data drive value, always low
  output logic                   sda_oe,            // High while pulling data low
  input  wire logic              addr_select_pin_0, // Address select strap 0
  input  wire logic              addr_select_pin_1, // Address select strap 1
  input  wire logic              addr_select_pin_2, // Address select strap 2
  input  wire logic              wr_valid,          // Array load word offered
  output logic                   wr_ready,          // Load FIFO has room
  input  wire logic [ADDR_W-1:0] wr_addr,           // Array load address
  input  wire logic [7:0]        wr_data            // Array load byte
);
  localparam int DEPTH = KBITS * 128;
  localparam int HI    = ADDR_W - IERP_BYTE_ADDR_W;  // Slave address bits used as array address
  localparam int FW    = ADDR_W + 8;

  // Synchronisers: first stage feeds only the second
  logic [5:0]  sync_m_q;
  logic [5:0]  sync_s_q;
  logic        scl_p_q;
  logic        sda_p_q;
  wire         scl_s = sync_s_q[0];
  wire         sda_s = sync_s_q[1];
  wire         por_s = sync_s_q[2];
  wire  [2:0]  pins_s = sync_s_q[5:3];

  ierp_state_t       st_q, st_d;
  logic [3:0]        cnt_q, cnt_d;
  logic [7:0]        sh_q, sh_d;
  logic              oe_q, oe_d;
  logic [ADDR_W-1:0] ptr_q, ptr_d;
  logic [2:0]        dev_q, dev_d;
  logic              rw_q, rw_d;
  logic              mack_q, mack_d;
  logic [7:0]        mem_q [DEPTH];

  wire               scl_rise  = scl_s && !scl_p_q;
  wire               scl_fall  = !scl_s && scl_p_q;
  wire               start_det = scl_s && scl_p_q && sda_p_q && !sda_s;
  wire               stop_det  = scl_s && scl_p_q && !sda_p_q && sda_s;
  wire  [7:0]        rd_byte   = mem_q[ptr_q];
  wire               byte_done = scl_fall && (cnt_q == IERP_BITS_PER_BYTE);
  wire               tx_done   = scl_fall && (cnt_q == IERP_LAST_TX_BIT);
  wire  [ADDR_W-1:0] ptr_load  = ADDR_W'({dev_q, sh_q});
  wire               addr_hit;
  wire               fifo_valid;
  wire  [FW-1:0]     fifo_data;
  wire               drain     = (st_q == ST_IDLE);

  // Pins stand in for bits not taken by the array address
  function automatic logic dev_match(input logic [7:0] b, input logic [2:0] pins);
    logic ok;
    ok = (b[7:4] == IERP_DEV_PATTERN);
    for (int i = 0; i < 3; i++)
      if (i >= HI && b[i+1] != pins[i])
        ok = 1'b0;
    return ok;
  endfunction

  assign addr_hit = dev_match(sh_q, pins_s);
  assign sda_o    = 1'b0;
  assign sda_oe   = oe_q;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      sync_m_q <= {6{IERP_SYNC_RST}};
      sync_s_q <= {6{IERP_SYNC_RST}};
      scl_p_q  <= IERP_SYNC_RST;
      sda_p_q  <= IERP_SYNC_RST;
    end
    else
    begin
      sync_m_q <= {addr_select_pin_2, addr_select_pin_1, addr_select_pin_0, por_ok, sda_i, scl_i};
      sync_s_q <= sync_m_q;
      scl_p_q  <= scl_s;
      sda_p_q  <= sda_s;
    end
  end

  always_comb
  begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    sh_d   = sh_q;
    oe_d   = oe_q;
    ptr_d  = ptr_q;
    dev_d  = dev_q;
    rw_d   = rw_q;
    mack_d = mack_q;
    if (!por_s)
    begin
      st_d = ST_RESET;
      oe_d = 1'b0;
    end
    else if (start_det)
    begin
      // Also serves the repeated START of a random read
      st_d  = ST_DEVADDR;
      cnt_d = '0;
      oe_d  = 1'b0;
    end
    else if (stop_det)
    begin
      st_d = ST_IDLE;
      oe_d = 1'b0;
    end
    else
    begin
      case (st_q)
        ST_RESET:
          st_d = ST_IDLE;
        ST_IDLE:
          oe_d = 1'b0;
        ST_DEVADDR, ST_BYTEADDR:
          if (scl_rise && cnt_q != IERP_BITS_PER_BYTE)
          begin
            sh_d  = {sh_q[6:0], sda_s};
            cnt_d = cnt_q + 1'b1;
          end
          else if (byte_done && st_q == ST_DEVADDR)
          begin
            st_d  = addr_hit ? ST_ADDR_ACK : ST_IDLE;
            oe_d  = addr_hit;
            dev_d = sh_q[3:1];
            rw_d  = sh_q[0];
          end
          else if (byte_done)
          begin
            st_d  = ST_BA_ACK;
            oe_d  = 1'b1;
            ptr_d = ptr_load;
          end
        ST_ADDR_ACK:
          if (scl_fall && rw_q)
          begin
            st_d  = ST_TX;
            sh_d  = rd_byte;
            oe_d  = !rd_byte[7];
            cnt_d = '0;
          end
          else if (scl_fall)
          begin
            st_d  = ST_BYTEADDR;
            oe_d  = 1'b0;
            cnt_d = '0;
          end
        // Data bytes of a write are outside this path: ignored until START
        ST_BA_ACK:
          if (scl_fall)
          begin
            st_d = ST_IDLE;
            oe_d = 1'b0;
          end
        ST_TX:
          if (tx_done)
          begin
            st_d  = ST_TX_ACK;
            oe_d  = 1'b0;
            ptr_d = ptr_q + 1'b1;
          end
          else if (scl_fall)
          begin
            sh_d  = {sh_q[6:0], 1'b0};
            oe_d  = !sh_q[6];
            cnt_d = cnt_q + 1'b1;
          end
        ST_TX_ACK:
          if (scl_rise)
            mack_d = !sda_s;
          else if (scl_fall && mack_q)
          begin
            st_d  = ST_TX;
            sh_d  = rd_byte;
            oe_d  = !rd_byte[7];
            cnt_d = '0;
          end
          else if (scl_fall)
            st_d = ST_IDLE;
        default:
          st_d = ST_RESET;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      st_q   <= ST_RESET;
      cnt_q  <= '0;
      sh_q   <= '0;
      oe_q   <= 1'b0;
      ptr_q  <= '0;
      dev_q  <= '0;
      rw_q   <= 1'b0;
      mack_q <= 1'b0;
    end
    else
    begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      sh_q   <= sh_d;
      oe_q   <= oe_d;
      ptr_q  <= ptr_d;
      dev_q  <= dev_d;
      rw_q   <= rw_d;
      mack_q <= mack_d;
    end
  end

  // Loads land only while the slave sits in ST_IDLE, so a byte never changes under the shifter
  ierp_fifo #(
    .W     (FW),
    .DEPTH (IERP_FIFO_DEPTH)
  ) u_load_fifo (
    .clk       (ref_clk),
    .rst       (sys_rst),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   ({wr_addr, wr_data}),
    .out_valid (fifo_valid),
    .out_ready (drain),
    .out_data  (fifo_data)
  );

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= IERP_ERASED;
    end
    else if (fifo_valid && drain)
      mem_q[fifo_data[FW-1:8]] <= fifo_data[7:0];
  end

  // Size check: only the four documented densities are legal
  initial
  begin
    if (!(KBITS == 2 || KBITS == 4 || KBITS == 8 || KBITS == 16))
      $error("ierp_top: KBITS must be 2, 4, 8 or 16");
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  addr_ack_a: assert property ((st_q == ST_DEVADDR) && byte_done && addr_hit && por_s && !start_det && !stop_det
    |=> st_q == ST_ADDR_ACK && sda_oe)
    else $error("matching slave address not acknowledged");
  addr_miss_a: assert property ((st_q == ST_DEVADDR) && byte_done && !addr_hit && por_s && !start_det && !stop_det
    |=> st_q == ST_IDLE && !sda_oe)
    else $error("foreign slave address acknowledged");
  tx_load_a: assert property ((st_q == ST_ADDR_ACK) && scl_fall && rw_q && por_s && !start_det && !stop_det
    |=> st_q == ST_TX && sh_q == $past(rd_byte) && sda_oe == !$past(rd_byte[7]))
    else $error("read byte not loaded from pointer");
  ninth_rel_a: assert property ((st_q == ST_TX) && tx_done && por_s && !start_det && !stop_det
    |=> st_q == ST_TX_ACK && !sda_oe)
    else $error("data line not released on ninth clock");
  ptr_step_a: assert property ((st_q == ST_TX) && tx_done && por_s && !start_det && !stop_det
    |=> ptr_q == ADDR_W'($past(ptr_q) + 1'b1))
    else $error("pointer did not advance after byte");
  seq_cont_a: assert property ((st_q == ST_TX_ACK) && scl_fall && mack_q && por_s && !start_det && !stop_det
    |=> st_q == ST_TX && sh_q == $past(rd_byte))
    else $error("acknowledged read did not continue");
  stop_idle_a: assert property (stop_det && por_s && !start_det |=> st_q == ST_IDLE && !sda_oe)
    else $error("STOP did not return to standby");
  por_low_a: assert property (!por_s |=> st_q == ST_RESET && !sda_oe)
    else $error("low supply did not force reset state");
  por_up_a: assert property ((st_q == ST_RESET) && por_s && !start_det && !stop_det |=> st_q == ST_IDLE)
    else $error("good supply did not reach standby");
  ba_load_a: assert property ((st_q == ST_BYTEADDR) && byte_done && por_s && !start_det && !stop_det
    |=> ptr_q[7:0] == $past(sh_q) && st_q == ST_BA_ACK && sda_oe)
    else $error("byte address not loaded into pointer");
  idle_quiet_a: assert property (st_q == ST_IDLE |-> !sda_oe)
    else $error("data line driven without START");
  erased_a: assert property ($fell(sys_rst) |-> rd_byte == IERP_ERASED)
    else $error("array not erased after reset");

  imm_read_c: cover property ((st_q == ST_ADDR_ACK) && scl_fall && rw_q);
  seq_read_c: cover property ((st_q == ST_TX_ACK) && scl_fall && mack_q);
  rand_read_c: cover property ((st_q == ST_BA_ACK) ##[1:400] start_det);
  fifo_full_c: cover property (!wr_ready);
endmodule

// File: test/ierp_master.sv
// Bus master model: drives the serial clock and shares the data wire
`timescale 1ns/1ps

module ierp_master (
  input  wire logic clk,  // Bench clock, paces every phase
  input  wire logic sda,  // Resolved data wire
  output logic      scl,  // Bus clock, still between frames
  output logic      m_oe  // High while pulling data low
);
  initial
  begin
    scl  = 1'b1;
    m_oe = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Also the repeated start; waits out the slave's ack release first
  task automatic start();
    wt(5);
    m_oe = 1'b0;
    wt(10);
    scl = 1'b1;
    wt(10);
    m_oe = 1'b1;
    wt(10);
    scl = 1'b0;
    wt(5);
  endtask

  task automatic stop();
    wt(5);
    m_oe = 1'b1;
    wt(5);
    scl = 1'b1;
    wt(10);
    m_oe = 1'b0;
    wt(10);
  endtask

  // Eight bits MSB first plus the ninth; data moves only while the clock is low
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--)
    begin
      wt(5);
      m_oe = !d[i];
      wt(5);
      scl = 1'b1;
      wt(5);
      q[i] = sda;
      wt(5);
      scl = 1'b0;
    end
  endtask
endmodule

// File: test/tb_top.sv
// Self-checking bench for the serial EEPROM read path
`timescale 1ns/1ps

module tb_top;
  import ierp_pkg::*;
  localparam logic [2:0] PINS = 3'h5;
  localparam logic [7:0] SA_W = {IERP_DEV_PATTERN, PINS, 1'b0};
  logic       ref_clk, sys_rst, por_ok, scl, m_oe, sda_oe, sda_o, wr_valid, wr_ready;
  logic [7:0] wr_addr, wr_data, ptr;
  logic [7:0] mem [256];
  logic [8:0] q;
  int         failures, num_checks;
  wire logic  sda = !(sda_oe | m_oe);

  ierp_top dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .por_ok(por_ok), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .addr_select_pin_0(PINS[0]), .addr_select_pin_1(PINS[1]),
    .addr_select_pin_2(PINS[2]), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr),
    .wr_data(wr_data)
  );

  ierp_master m (.clk(ref_clk), .sda(sda), .scl(scl), .m_oe(m_oe));

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic send(input logic [7:0] b, input logic ack);
    m.xfer({b, 1'b1}, q);
    check("ack", {7'h00, q[0]}, {7'h00, !ack});
  endtask

  task automatic seek(input logic [7:0] a);
    m.start();
    send(SA_W, 1'b1);
    send(a, 1'b1);
    ptr = a;
  endtask

  // Master acks all but the last byte, then stops
  task automatic rd(input int n);
    m.start();
    send(SA_W | 8'h01, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      m.xfer({8'hFF, i == n - 1}, q);
      check("data", q[8:1], mem[ptr]);
      check("ninth", {7'h00, q[0]}, {7'h00, i == n - 1});
      ptr++;
    end
    m.stop();
  endtask

  // Valid stays high across words so it is never set twice in one step
  task automatic load(input logic [7:0] a, input int n, input logic [7:0] d);
    int k;
    wr_valid = 1'b1;
    for (int i = 0; i < n; i++)
    begin
      wr_addr = a + i[7:0];
      wr_data = d + i[7:0];
      k = 0;
      while (wr_ready !== 1'b1 && k < 200)
      begin
        @(negedge ref_clk);
        k++;
      end
      if (k == 200)
        failures++;
      @(negedge ref_clk);
      mem[wr_addr] = wr_data;
    end
    wr_valid = 1'b0;
  endtask

  task automatic t_erased();
    seek(8'h10);
    rd(3);
  endtask

  task automatic t_wrap();
    load(8'hFE, 4, 8'hA5);
    seek(8'hFE);
    rd(4);
    rd(1);
  endtask

  // Bus busy holds the drain off, so the FIFO fills and refuses
  task automatic t_fill();
    m.start();
    send(SA_W, 1'b1);
    load(8'h40, 8, 8'h30);
    check("full", {7'h00, wr_ready}, 8'h00);
    send(8'h40, 1'b1);
    m.stop();
    m.wt(20);
    check("ready", {7'h00, wr_ready}, 8'h01);
    ptr = 8'h40;
    rd(8);
  endtask

  task automatic t_refuse();
    m.xfer({SA_W | 8'h01, 1'b1}, q);
    check("nostart", {7'h00, q[0]}, 8'h01);
    m.stop();
    for (int i = 0; i < 3; i++)
    begin
      m.start();
      send(i == 0 ? 8'hA3 : (i == 1 ? 8'hBB : 8'hA9), 1'b0);
      m.stop();
    end
  endtask

  // Supply drops with the falling edge that ends the address ack, so the device is still pulling low for its ack
  task automatic t_por();
    seek(8'h40);
    m.start();
    send(SA_W | 8'h01, 1'b1);
    check("sda_o", {7'h00, sda_o}, 8'h00);
    por_ok = 1'b0;
    m.wt(8);
    check("oe_low", {7'h00, sda_oe}, 8'h00);
    m.xfer({8'hFF, 1'b1}, q);
    check("released", q[8:1], 8'hFF);
    m.stop();
    por_ok = 1'b1;
    m.wt(10);
    seek(8'hFE);
    rd(1);
  endtask

  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  initial
  begin
    #300000;
    failures++;
    give_verdict();
  end

  initial
  begin
    sys_rst    = 1'b1;
    por_ok     = 1'b1;
    wr_valid   = 1'b0;
    wr_addr    = 8'h00;
    wr_data    = 8'h00;
    ptr        = 8'h00;
    failures   = 0;
    num_checks = 0;
    foreach (mem[i])
      mem[i] = 8'hFF;
    repeat (4) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (10) @(negedge ref_clk);
    t_erased();
    t_wrap();
    t_fill();
    t_refuse();
    t_por();
    give_verdict();
  end
endmodule
